// [logic/mck_keyer.sv]
// morse chip keyer: walks a chip buffer on dit ticks and gates the tone
`timescale 1ns/10ps
`default_nettype none

// Behaviour
// RULE1 - tick period is one dit; all timing is whole multiples of ticks
// RULE2 - tick reload equals clock rate times 1.2 divided by words per minute
// RULE3 - current chip's on/off bit drives tone enable directly
// RULE4 - each tick decrements chip count; at zero advance to next chip
// RULE5 - after last chip, stop ticking and raise done
// RULE6 - each chip is one interval; three-mark letter uses six chips
// RULE7 - firmware translates text byte by byte through a lookup table
// RULE8 - space or comma gives word gap, full stop gives sentence gap
// RULE9 - rate, dit, dash, character and word gaps are configurable
// RULE10 - firmware takes chip counts from configured dit, dash, gap values
// RULE11 - a buffer holds about 25 characters; longer messages use successive buffers
// RULE12 - keying starts only after whole message is in the buffer
// RULE13 - at each new chip, a zero chip marks end of buffer
// RULE14 - each element is two bytes: tone-on time then tone-off time; code keys one-byte chips, bit 7 on/off and bits 6:0 ticks
// RULE15 - timeout timer starts per buffer and releases controller if too slow
// RULE16 - tone enable held low after reset and whenever idle
module mck_keyer (
    // clock and reset
    input wire logic i_clk,
    input wire logic i_reset_n,
    // buffer write port from firmware
    input wire logic i_wr_en,
    input wire logic [mck_pkg::ADDR_W-1:0] i_wr_addr,
    input wire mck_pkg::mck_chip_t i_wr_chip,
    // timing configuration and start
    input wire mck_pkg::mck_timing_t i_timing, // RULE9
    input wire logic i_start,
    // status and tone output
    output logic o_tone_en,
    output logic o_busy,
    output logic o_done,
    output logic o_timeout,
    output logic [mck_pkg::TIMER_W-1:0] o_tick_reload,
    output logic [mck_pkg::TIMER_W-1:0] o_timeout_limit
);
    mck_pkg::mck_chip_t chip_mem [mck_pkg::BUF_DEPTH];
    mck_pkg::mck_state_t state, next_state;
    logic [mck_pkg::ADDR_W-1:0] rd_ptr, next_rd_ptr;
    mck_pkg::mck_chip_t cur, next_cur;
    logic [mck_pkg::TIMER_W-1:0] tick_cnt, next_tick_cnt;
    logic [mck_pkg::TIMER_W-1:0] reload, next_reload;
    logic [mck_pkg::TIMER_W-1:0] to_cnt, next_to_cnt;
    logic tone, next_tone, done, next_done, tmo, next_tmo;
    logic tick;
    mck_pkg::mck_chip_t rd_chip;

    // chip buffer storage, written by firmware before start
    always_ff @(posedge i_clk) begin
        if (i_wr_en) begin
            chip_mem[i_wr_addr] <= i_wr_chip;
        end
    end
    assign rd_chip = chip_mem[rd_ptr];

    // dit tick when the timer counts down to zero
    assign tick = (state == mck_pkg::MCK_RUN) && (tick_cnt == '0); // RULE1

    // next state of the keying engine
    always_comb begin
        next_state = state;
        next_rd_ptr = rd_ptr;
        next_cur = cur;
        next_tick_cnt = tick_cnt;
        next_reload = reload;
        next_to_cnt = to_cnt;
        next_tone = 1'b0;
        next_done = done;
        next_tmo = tmo;
        unique case (state)
            mck_pkg::MCK_IDLE: begin
                if (i_start) begin // RULE12
                    // wpm of zero clamps to one to avoid divide by zero
                    next_reload = mck_pkg::TICKS_PER_WPM
                        / ((i_timing.wpm == '0) ? 32'h1 : 32'(i_timing.wpm)); // RULE2
                    next_rd_ptr = '0;
                    next_to_cnt = '0; // RULE15
                    next_done = 1'b0;
                    next_tmo = 1'b0;
                    next_state = mck_pkg::MCK_LOAD;
                end
            end
            mck_pkg::MCK_LOAD: begin
                if (rd_chip == '0) begin // RULE13
                    next_done = 1'b1; // RULE5
                    next_state = mck_pkg::MCK_IDLE;
                end else begin
                    next_cur = rd_chip; // RULE14
                    next_rd_ptr = rd_ptr + 1'b1; // RULE6
                    next_tick_cnt = reload - 32'h1;
                    next_tone = rd_chip.key_on; // RULE3
                    next_state = mck_pkg::MCK_RUN;
                end
            end
            mck_pkg::MCK_RUN: begin
                next_tone = cur.key_on; // RULE3
                next_tick_cnt = tick ? reload - 32'h1 : tick_cnt - 32'h1;
                if (tick) begin
                    next_cur.count = cur.count - 1'b1; // RULE4
                    if (cur.count <= 7'h01) begin
                        next_tone = 1'b0;
                        next_state = mck_pkg::MCK_LOAD; // RULE4
                    end
                end
            end
            default: next_state = mck_pkg::MCK_IDLE;
        endcase
        // timeout releases the controller if sending runs too long
        if (state != mck_pkg::MCK_IDLE) begin
            if (to_cnt >= mck_pkg::TIMEOUT_CYCLES - 32'h1) begin // RULE15
                next_tmo = 1'b1;
                next_done = 1'b1;
                next_tone = 1'b0;
                next_state = mck_pkg::MCK_IDLE;
            end else begin
                next_to_cnt = to_cnt + 32'h1;
            end
        end
    end

    // state registers
    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            state <= mck_pkg::MCK_IDLE;
            rd_ptr <= '0;
            cur <= '0;
            tick_cnt <= '0;
            reload <= '0;
            to_cnt <= '0;
            tone <= 1'b0; // RULE16
            done <= 1'b0;
            tmo <= 1'b0;
        end else begin
            state <= next_state;
            rd_ptr <= next_rd_ptr;
            cur <= next_cur;
            tick_cnt <= next_tick_cnt;
            reload <= next_reload;
            to_cnt <= next_to_cnt;
            tone <= next_tone;
            done <= next_done;
            tmo <= next_tmo;
        end
    end

    // outputs
    assign o_tone_en = tone;
    assign o_busy = (state != mck_pkg::MCK_IDLE);
    assign o_done = done;
    assign o_timeout = tmo;
    assign o_tick_reload = reload;
    assign o_timeout_limit = mck_pkg::TIMEOUT_CYCLES;

    // checks
    a_idle_tone_low: assert property (@(posedge i_clk) disable iff (!i_reset_n)
        (state == mck_pkg::MCK_IDLE) |=> !o_tone_en || $past(state) != mck_pkg::MCK_IDLE) // RULE16
        else $error("tone enabled while idle");
    a_tone_follows_chip: assert property (@(posedge i_clk) disable iff (!i_reset_n)
        (state == mck_pkg::MCK_RUN && !tick) |=> o_tone_en == $past(cur.key_on)) // RULE3
        else $error("tone differs from chip bit");
    a_count_dec: assert property (@(posedge i_clk) disable iff (!i_reset_n)
        (tick && cur.count > 7'h01 && to_cnt < mck_pkg::TIMEOUT_CYCLES - 32'h1)
        |=> cur.count == $past(cur.count) - 7'h01) // RULE4
        else $error("chip count not decremented");
    a_chip_advance: assert property (@(posedge i_clk) disable iff (!i_reset_n)
        (tick && cur.count == 7'h01 && to_cnt < mck_pkg::TIMEOUT_CYCLES - 32'h1)
        |=> state == mck_pkg::MCK_LOAD) // RULE4
        else $error("chip not dropped at zero");
    a_end_marker: assert property (@(posedge i_clk) disable iff (!i_reset_n)
        (state == mck_pkg::MCK_LOAD && rd_chip == '0) |=> o_done && !o_busy) // RULE13
        else $error("end marker not honoured");
    a_done_stops: assert property (@(posedge i_clk) disable iff (!i_reset_n)
        $rose(o_done) |-> !o_busy ##1 !o_tone_en) // RULE5
        else $error("engine runs after done");
    a_tick_period: assert property (@(posedge i_clk) disable iff (!i_reset_n)
        (state == mck_pkg::MCK_LOAD && rd_chip != '0) |=> tick_cnt == reload - 32'h1) // RULE1
        else $error("tick timer not reloaded");
    a_reload_calc: assert property (@(posedge i_clk) disable iff (!i_reset_n)
        (state == mck_pkg::MCK_IDLE && i_start && i_timing.wpm == 8'h0C)
        |=> reload == 32'h003D0900) // RULE2
        else $error("reload not 1.2/wpm");
    a_timeout_fire: assert property (@(posedge i_clk) disable iff (!i_reset_n)
        (o_busy && to_cnt == mck_pkg::TIMEOUT_CYCLES - 32'h1) |=> o_timeout && !o_busy) // RULE15
        else $error("timeout did not release");

    // one chip being loaded, and the keyed interval that follows it
    sequence s_chip_load;
        state == mck_pkg::MCK_LOAD && rd_chip != '0 && to_cnt < mck_pkg::TIMEOUT_CYCLES - 32'h1;
    endsequence
    sequence s_chip_keyed;
        state == mck_pkg::MCK_RUN && o_tone_en == cur.key_on;
    endsequence
    a_load_keys_tone: assert property (@(posedge i_clk) disable iff (!i_reset_n)
        s_chip_load |=> s_chip_keyed) // RULE3
        else $error("loaded chip not keyed");
    // the read pointer moves one chip forward per load
    a_ptr_step: assert property (@(posedge i_clk) disable iff (!i_reset_n)
        s_chip_load |=> rd_ptr == $past(rd_ptr) + 8'h01) // RULE6
        else $error("read pointer did not advance");
    // a start from idle clears the previous verdict and makes the engine busy
    a_start_taken: assert property (@(posedge i_clk) disable iff (!i_reset_n)
        (state == mck_pkg::MCK_IDLE && i_start) |=> o_busy && !o_done && !o_timeout) // RULE12
        else $error("start not taken");
    // the tone stays off through every load cycle
    a_load_tone_low: assert property (@(posedge i_clk) disable iff (!i_reset_n)
        (state == mck_pkg::MCK_LOAD) |-> !o_tone_en) // RULE16
        else $error("tone on during load");
    // the tick length is fixed for the whole buffer
    a_reload_stable: assert property (@(posedge i_clk) disable iff (!i_reset_n)
        o_busy |=> $stable(o_tick_reload)) // RULE1
        else $error("tick reload changed while busy");
    // a timeout always releases the controller through done
    a_timeout_done: assert property (@(posedge i_clk) disable iff (!i_reset_n)
        o_timeout |-> o_done) // RULE15
        else $error("timeout without done");
endmodule // mck_keyer

`default_nettype wire

// [logic/mck_pkg.sv]
// package for the morse chip keyer: constants, chip format and states
package mck_pkg;
    // chip buffer geometry: about 25 characters, up to 6 chips each plus gaps
    localparam int BUF_DEPTH = 256;
    localparam int ADDR_W = 8;
    localparam int COUNT_W = 7;
    // chip layout: bit 7 tone on, bits 6:0 duration in ticks; zero chip ends the buffer
    localparam int CHIP_W = 8;
    localparam int KEY_BIT = 7;
    // clock and tick derivation: dit seconds = 1.2 / wpm
    localparam longint CLK_HZ = 40000000;
    localparam longint DIT_NUM = 12;
    localparam longint DIT_DEN = 10;
    localparam logic [31:0] TICKS_PER_WPM = 32'(CLK_HZ * DIT_NUM / DIT_DEN);
    localparam int WPM_W = 8;
    localparam int TIMER_W = 32;
    // default timeout in clock cycles (20 s)
    localparam logic [31:0] TIMEOUT_CYCLES = 32'h2FAF0800;
    // defaults for configurable timing in ticks
    localparam logic [6:0] DIT_TICKS = 7'h01;
    localparam logic [6:0] DAH_TICKS = 7'h03;

    typedef struct packed {
        logic key_on;
        logic [COUNT_W-1:0] count;
    } mck_chip_t;

    typedef struct packed {
        logic [WPM_W-1:0] wpm;
        logic [COUNT_W-1:0] dit_len;
        logic [COUNT_W-1:0] dah_len;
        logic [COUNT_W-1:0] char_gap;
        logic [COUNT_W-1:0] word_gap;
    } mck_timing_t;

    typedef enum logic [1:0] {
        MCK_IDLE,
        MCK_LOAD,
        MCK_RUN
    } mck_state_t;
endpackage

// [sim/mck_tone_model.sv]
// tone generator model: counts the cycles in which the tone is keyed on
`timescale 1ns/10ps
`default_nettype none
module mck_tone_model (
    // clock and reset
    input wire logic i_clk,
    input wire logic i_reset_n,
    // tone enable from the keyer
    input wire logic i_tone_en,
    // keyed-on cycle count
    output logic [31:0] o_on_cycles
);
    // accumulate keyed cycles so the bench can judge interval lengths
    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            o_on_cycles <= 32'h0;
        end else if (i_tone_en) begin
            o_on_cycles <= o_on_cycles + 32'h1;
        end
    end
endmodule // mck_tone_model
`default_nettype wire

// [sim/tb_top.sv]
// testbench for the morse chip keyer
`timescale 1ns/10ps
`default_nettype none
module tb_top;
    logic i_clk = 1'b0, i_reset_n = 1'b0, i_wr_en = 1'b0, i_start = 1'b0;
    logic [7:0] i_wr_addr = 8'h00;
    mck_pkg::mck_chip_t i_wr_chip = '0;
    mck_pkg::mck_timing_t i_timing = {8'hFF, 7'h01, 7'h03, 7'h03, 7'h07};
    logic o_tone_en, o_busy, o_done, o_timeout;
    logic [31:0] o_tick_reload, o_timeout_limit, on_cycles, base;
    int n_fail = 0, n_compared = 0;
    // 40 MHz clock
    always #12.5 i_clk = ~i_clk;
    mck_keyer mck_keyer_inst (.i_clk(i_clk), .i_reset_n(i_reset_n), .i_wr_en(i_wr_en),
        .i_wr_addr(i_wr_addr), .i_wr_chip(i_wr_chip), .i_timing(i_timing),
        .i_start(i_start), .o_tone_en(o_tone_en), .o_busy(o_busy), .o_done(o_done),
        .o_timeout(o_timeout), .o_tick_reload(o_tick_reload),
        .o_timeout_limit(o_timeout_limit));
    mck_tone_model mck_tone_model_inst (.i_clk(i_clk), .i_reset_n(i_reset_n),
        .i_tone_en(o_tone_en), .o_on_cycles(on_cycles));
    // compare and report
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            n_fail++;
            $display("ERROR at %0t: saw %h, expected %h", $time, seen, exp);
        end
    endtask
    task automatic end_of_test();
        if (n_fail == 0 && n_compared > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask
    // advance to just after a rising edge
    task automatic step(input int n);
        repeat (n) @(posedge i_clk);
        #1;
    endtask
    // firmware writes one chip of a translated buffer
    task automatic wr(input logic [7:0] a, input logic [7:0] c);
        i_wr_en = 1'b1;
        i_wr_addr = a;
        i_wr_chip = c;
        step(1);
        i_wr_en = 1'b0;
    endtask
    // start, then wait for done under a bound
    task automatic run(input int limit);
        int k;
        k = 0;
        i_start = 1'b1;
        step(1);
        i_start = 1'b0;
        step(2);
        i_start = 1'b1; // ignored while busy; restarts the engine if it is already done and idle
        step(1);
        i_start = 1'b0;
        while (o_done !== 1'b1 && k < limit) begin
            step(1);
            k++;
        end
    endtask
    task automatic t_reset();
        chk({o_tone_en, o_busy, o_done, o_timeout}, 32'h0);
        chk(o_timeout_limit, mck_pkg::TIMEOUT_CYCLES);
    endtask
    task automatic t_reload();
        logic [7:0] w [5] = '{8'h01, 8'h14, 8'h00, 8'h0C, 8'hFF};
        for (int i = 0; i < 5; i++) begin
            i_timing.wpm = w[i];
            i_start = 1'b1;
            step(1);
            i_start = 1'b0;
            step(3);
            chk(o_tick_reload, mck_pkg::TICKS_PER_WPM / ((w[i] == 8'h00) ? 1 : w[i]));
        end
    endtask
    task automatic t_empty();
        wr(8'h00, 8'h00);
        run(20);
        chk({o_done, o_busy, o_tone_en}, 32'h4);
        chk(on_cycles, 32'h0);
    endtask
    // one on chip and its off chip; a mid-run reset cuts the long tick
    task automatic t_one_chip();
        wr(8'h00, 8'h81);
        wr(8'h01, 8'h01);
        wr(8'h02, 8'h00);
        base = on_cycles;
        run(1000);
        chk(on_cycles - base, 32'h3EA);
        chk({o_done, o_busy, o_tone_en, o_timeout}, 32'h6);
        i_reset_n = 1'b0;
        step(1);
        chk({o_done, o_busy, o_tone_en, o_timeout}, 32'h0);
        i_reset_n = 1'b1;
        step(2);
        chk({o_done, o_busy, o_tone_en, o_timeout}, 32'h0);
    endtask
    // main sequence
    initial begin
        step(6);
        i_reset_n = 1'b1;
        step(1);
        t_reset();
        t_empty();
        t_reload();
        t_one_chip();
        end_of_test();
    end
    // watchdog
    initial begin
        #(25 * 20000);
        n_fail++;
        end_of_test();
    end
endmodule // tb_top
`default_nettype wire
